// ==== pdm_pkg.sv ====
// package: constants for the program and data memory map block
package pdm_pkg;
   localparam int PC_W      = 13;
   localparam int WORD_W    = 14;
   localparam int PROG_AW   = 10;
   localparam int DATA_W    = 8;
   localparam int DADDR_W   = 7;
   localparam int EADDR_W   = 8;
   localparam int GPR_AW    = 6;
   localparam int GPR_DEPTH = 64;
   localparam logic [PC_W-1:0]    RESET_VECTOR = 13'h0000;
   localparam logic [PC_W-1:0]    INT_VECTOR   = 13'h0004;
   localparam logic [DADDR_W-1:0] SFR_LIMIT    = 7'h20;
   localparam logic [DADDR_W-1:0] GPR_FIRST    = 7'h20;
   localparam logic [DADDR_W-1:0] GPR_LAST     = 7'h5F;
   localparam logic [DADDR_W-1:0] INDIRECT_LOC = 7'h00;
   localparam logic [DADDR_W-1:0] STATUS_OFFSET = 7'h03;
   localparam logic [DADDR_W-1:0] PTR_OFFSET    = 7'h04;
   localparam int BANK_BIT_POS  = 5;
   localparam int UPPER_BIT_POS = 6;
   localparam int IND_BIT_POS   = 7;
   localparam logic [DATA_W-1:0]  STATUS_RESET = 8'h18;
   localparam logic [DATA_W-1:0]  PTR_RESET    = 8'h00;
   typedef enum logic [1:0] {
      PDM_REG_NONE = 2'b00,
      PDM_REG_SFR  = 2'b01,
      PDM_REG_GPR  = 2'b10
   } pdm_region_e;
endpackage : pdm_pkg

// ==== pdm_gpr_ram.sv ====
// shared general purpose ram with registered read data
module pdm_gpr_ram
   import pdm_pkg::*;
#(
   parameter int DEPTH = GPR_DEPTH,
   parameter int AW    = GPR_AW
) (
   input  wire logic              core_clk,
   input  wire logic              wr_en,
   input  wire logic [AW-1:0]     wr_addr,
   input  wire logic [DATA_W-1:0] wr_data,
   input  wire logic [AW-1:0]     rd_addr,
   output logic      [DATA_W-1:0] rd_data
);
   logic [DATA_W-1:0] mem [DEPTH];

   always_ff @(posedge core_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule : pdm_gpr_ram

// ==== pdm_memory_map.sv ====
// program counter, vectors and banked data address decode
module pdm_memory_map
   import pdm_pkg::*;
#(
   parameter int PCW = PC_W
) (
   input  wire logic               core_clk,
   input  wire logic               reset,
   // program side
   input  wire logic               pc_advance,
   input  wire logic               pc_load,
   input  wire logic [PCW-1:0]     pc_load_value,
   input  wire logic               int_take,
   output logic      [PCW-1:0]     pc,
   output logic      [PROG_AW-1:0] prog_word_addr,
   // data side
   input  wire logic               data_req,
   input  wire logic               data_we,
   input  wire logic [DADDR_W-1:0] data_addr,
   input  wire logic [DATA_W-1:0]  data_wdata,
   output logic                    data_rvalid,
   output logic      [DATA_W-1:0]  data_rdata,
   output logic                    sfr_sel,
   output logic                    sfr_we,
   output logic      [EADDR_W-1:0] sfr_addr,
   output logic      [DATA_W-1:0]  sfr_wdata,
   input  wire logic [DATA_W-1:0]  sfr_rdata,
   output logic      [DATA_W-1:0]  status_reg,
   output logic      [DATA_W-1:0]  indirect_pointer_register,
   output logic                    bank_select_bit
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [PCW-1:0]    pc;
      logic [DATA_W-1:0] status;
      logic [DATA_W-1:0] ptr;
      logic              rvalid;
      pdm_region_e       rd_region;
      logic [DATA_W-1:0] sfr_capture;
   } pdm_state_s;

   pdm_state_s st_q;
   pdm_state_s st_d;

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   function automatic pdm_region_e pdm_decode(input logic [DADDR_W-1:0] a);
      if (a < SFR_LIMIT) begin
         return PDM_REG_SFR;
      end else if (a >= GPR_FIRST && a <= GPR_LAST) begin
         return PDM_REG_GPR;
      end else begin
         return PDM_REG_NONE;
      end
   endfunction : pdm_decode

   logic [EADDR_W-1:0] direct_ea;
   logic [EADDR_W-1:0] eff_addr;
   logic [DADDR_W-1:0] offset;
   pdm_region_e        region;
   logic               gpr_we;
   logic [DATA_W-1:0]  gpr_rdata;
   logic               hit_status;
   logic               hit_ptr;

   // status bits 7:6 are stored as written; software must keep them low
   assign direct_ea  = {st_q.status[BANK_BIT_POS], data_addr};
   // pointer carries its own bank in bit 7, so indirect reach spans both banks
   assign eff_addr   = (data_addr == INDIRECT_LOC) ? st_q.ptr : direct_ea;
   assign offset     = eff_addr[DADDR_W-1:0];
   assign region     = pdm_decode(offset);
   // status and pointer sit here in both banks, so either bank sees one copy
   assign hit_status = (region == PDM_REG_SFR) && (offset == STATUS_OFFSET);
   assign hit_ptr    = (region == PDM_REG_SFR) && (offset == PTR_OFFSET);
   assign gpr_we     = data_req && data_we && (region == PDM_REG_GPR);

   always_comb begin
      st_d        = st_q;
      // rvalid follows each read request one cycle later, so back-to-back reads hold it high
      st_d.rvalid = data_req && !data_we;
      if (data_req && !data_we) begin
         st_d.rd_region = region;
         st_d.sfr_capture = hit_status ? st_q.status :
                            hit_ptr    ? st_q.ptr    : sfr_rdata;
      end
      if (int_take) begin
         st_d.pc = INT_VECTOR;
      end else if (pc_load) begin
         st_d.pc = pc_load_value;
      end else if (pc_advance) begin
         st_d.pc = PCW'(st_q.pc + 1'b1);
      end
      if (data_req && data_we && hit_status) begin
         st_d.status = data_wdata;
      end
      if (data_req && data_we && hit_ptr) begin
         st_d.ptr = data_wdata;
      end
      if (reset) begin
         st_d.pc          = RESET_VECTOR;
         st_d.status      = STATUS_RESET;
         st_d.ptr         = PTR_RESET;
         st_d.rvalid      = 1'b0;
         st_d.rd_region   = PDM_REG_NONE;
         st_d.sfr_capture = '0;
      end
   end

   always_ff @(posedge core_clk) begin
      st_q <= st_d;
   end

   // ------------------------------------------------------------
   // shared ram, one copy for both banks
   // ------------------------------------------------------------
   pdm_gpr_ram #(
      .DEPTH (GPR_DEPTH),
      .AW    (GPR_AW)
   ) u_ram (
      .core_clk (core_clk),
      .wr_en    (gpr_we),
      .wr_addr  (GPR_AW'(offset - GPR_FIRST)),
      .wr_data  (data_wdata),
      .rd_addr  (GPR_AW'(offset - GPR_FIRST)),
      .rd_data  (gpr_rdata)
   );

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign pc             = st_q.pc;
   assign prog_word_addr = st_q.pc[PROG_AW-1:0];
   assign data_rvalid    = st_q.rvalid;
   always_comb begin
      case (st_q.rd_region)
         PDM_REG_SFR: data_rdata = st_q.sfr_capture;
         PDM_REG_GPR: data_rdata = gpr_rdata;
         default:     data_rdata = '0;
      endcase
   end
   assign sfr_sel    = data_req && (region == PDM_REG_SFR);
   assign sfr_we     = data_req && data_we && (region == PDM_REG_SFR);
   assign sfr_addr   = eff_addr;
   assign sfr_wdata  = data_wdata;
   assign status_reg = st_q.status;
   assign indirect_pointer_register = st_q.ptr;
   assign bank_select_bit = st_q.status[BANK_BIT_POS];

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence s_rd_req_none;
      data_req && !data_we && (region == PDM_REG_NONE);
   endsequence

   property p_reset_vector;
      @(posedge core_clk) reset |=> (pc == 13'h0000);
   endproperty
   a_reset_vector: assert property (p_reset_vector) else $error("pc not at reset vector");

   property p_int_vector;
      @(posedge core_clk) disable iff (reset) int_take |=> (pc == 13'h0004);
   endproperty
   a_int_vector: assert property (p_int_vector) else $error("pc not at int vector");

   property p_pc_wrap;
      @(posedge core_clk) disable iff (reset)
         (pc == 13'h1FFF) && pc_advance && !pc_load && !int_take |=> (pc == 13'h0000);
   endproperty
   a_pc_wrap: assert property (p_pc_wrap) else $error("pc did not wrap at 13 bits");

   property p_prog_low_bits;
      @(posedge core_clk) disable iff (reset) prog_word_addr == pc[9:0];
   endproperty
   a_prog_low_bits: assert property (p_prog_low_bits) else $error("program word not folded");

   property p_none_zero;
      @(posedge core_clk) disable iff (reset) s_rd_req_none |=> (data_rvalid && data_rdata == 8'h00);
   endproperty
   a_none_zero: assert property (p_none_zero) else $error("unimplemented read not zero");

   property p_sfr_low;
      @(posedge core_clk) disable iff (reset)
         data_req && data_addr != 7'h00 && data_addr < 7'h20 |-> sfr_sel;
   endproperty
   a_sfr_low: assert property (p_sfr_low) else $error("low address not sfr");

   property p_bank_addr;
      @(posedge core_clk) disable iff (reset)
         data_req && data_addr != 7'h00 |-> (sfr_addr == {status_reg[5], data_addr});
   endproperty
   a_bank_addr: assert property (p_bank_addr) else $error("bank bit not above address");

   property p_indirect;
      @(posedge core_clk) disable iff (reset)
         data_req && data_addr == 7'h00 |-> (sfr_addr == indirect_pointer_register);
   endproperty
   a_indirect: assert property (p_indirect) else $error("indirect not redirected");

   sequence s_ram_wr_bank0;
      data_req && data_we && (data_addr == GPR_LAST) && !status_reg[BANK_BIT_POS];
   endsequence

   sequence s_bank1_set;
      data_req && data_we && (data_addr == STATUS_OFFSET) && data_wdata[BANK_BIT_POS];
   endsequence

   sequence s_ram_rd_bank1;
      data_req && !data_we && (data_addr == GPR_LAST) && status_reg[BANK_BIT_POS];
   endsequence

   // outside reset the bank only moves through a status write, so the check spans three requests
   property p_shared_ram;
      @(posedge core_clk) disable iff (reset)
         s_ram_wr_bank0 ##1 s_bank1_set ##1 s_ram_rd_bank1
         |=> (data_rdata == $past(data_wdata, 3));
   endproperty
   a_shared_ram: assert property (p_shared_ram) else $error("ram not shared by banks");

   property p_bank_out;
      @(posedge core_clk) disable iff (reset) bank_select_bit == status_reg[5];
   endproperty
   a_bank_out: assert property (p_bank_out) else $error("bank select mismatch");

   // ------------------------------------------------------------
   // handshake, register and counter checks
   // ------------------------------------------------------------

   sequence s_rd_req;
      data_req && !data_we;
   endsequence

   sequence s_wr_req;
      data_req && data_we;
   endsequence

   property p_rvalid_pulse;
      @(posedge core_clk) disable iff (reset)
         s_rd_req |=> data_rvalid;
   endproperty
   a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read gave no rvalid");

   property p_no_rvalid;
      @(posedge core_clk) disable iff (reset)
         !(data_req && !data_we) |=> !data_rvalid;
   endproperty
   a_no_rvalid: assert property (p_no_rvalid) else $error("rvalid without a read");

   property p_status_write;
      @(posedge core_clk) disable iff (reset)
         s_wr_req ##0 hit_status |=> (status_reg == $past(data_wdata));
   endproperty
   a_status_write: assert property (p_status_write) else $error("status write lost");

   property p_ptr_write;
      @(posedge core_clk) disable iff (reset)
         s_wr_req ##0 hit_ptr |=> (indirect_pointer_register == $past(data_wdata));
   endproperty
   a_ptr_write: assert property (p_ptr_write) else $error("pointer write lost");

   property p_status_read;
      @(posedge core_clk) disable iff (reset)
         s_rd_req ##0 hit_status |=> (data_rdata == $past(status_reg));
   endproperty
   a_status_read: assert property (p_status_read) else $error("status read wrong");

   property p_ptr_read;
      @(posedge core_clk) disable iff (reset)
         s_rd_req ##0 hit_ptr |=> (data_rdata == $past(indirect_pointer_register));
   endproperty
   a_ptr_read: assert property (p_ptr_read) else $error("pointer read wrong");

   property p_sfr_capture;
      @(posedge core_clk) disable iff (reset)
         s_rd_req ##0 (sfr_sel && !hit_status && !hit_ptr) |=> (data_rdata == $past(sfr_rdata));
   endproperty
   a_sfr_capture: assert property (p_sfr_capture) else $error("sfr read wrong");

   property p_sfr_write;
      @(posedge core_clk) disable iff (reset)
         s_wr_req ##0 sfr_sel |-> sfr_we && (sfr_wdata == data_wdata);
   endproperty
   a_sfr_write: assert property (p_sfr_write) else $error("sfr write not passed");

   property p_gpr_not_sfr;
      @(posedge core_clk) disable iff (reset)
         data_req && (region == PDM_REG_GPR) |-> !sfr_sel && !sfr_we;
   endproperty
   a_gpr_not_sfr: assert property (p_gpr_not_sfr) else $error("ram access hit sfr");

   property p_none_quiet;
      @(posedge core_clk) disable iff (reset)
         data_req && (region == PDM_REG_NONE) |-> !sfr_sel && !gpr_we;
   endproperty
   a_none_quiet: assert property (p_none_quiet) else $error("unimplemented access acted");

   property p_pc_load;
      @(posedge core_clk) disable iff (reset)
         pc_load && !int_take |=> (pc == $past(pc_load_value));
   endproperty
   a_pc_load: assert property (p_pc_load) else $error("pc load lost");

   property p_pc_advance;
      @(posedge core_clk) disable iff (reset)
         pc_advance && !pc_load && !int_take |=> (pc == $past(pc) + 1'b1);
   endproperty
   a_pc_advance: assert property (p_pc_advance) else $error("pc did not advance");
endmodule : pdm_memory_map

// ==== pdm_sfr_model.sv ====
// far-side special function register bank answering the decoded sfr port
module pdm_sfr_model
   import pdm_pkg::*;
(
   input  wire logic               core_clk,
   input  wire logic               sfr_sel,
   input  wire logic [EADDR_W-1:0] sfr_addr,
   output logic      [DATA_W-1:0]  sfr_rdata
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [DATA_W-1:0] junk_q = 8'hC3;
   // deselected: moving pattern, so a stale sample never matches
   always_ff @(posedge core_clk) junk_q <= junk_q + 8'h35;
   assign sfr_rdata = sfr_sel ? (sfr_addr ^ 8'h5A) : junk_q;
endmodule : pdm_sfr_model

// ==== pdm_memory_map_bench.sv ====
// self-checking bench for the program and data memory map block
module pdm_memory_map_bench
   import pdm_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic                 core_clk = 1'h0, reset = 1'h1;
   logic                 pc_advance = 1'h0, pc_load = 1'h0, int_take = 1'h0;
   logic [PC_W-1:0]      pc_load_value = 13'h0000, pc;
   logic                 data_req = 1'h0, data_we = 1'h0;
   logic [DADDR_W-1:0]   data_addr = 7'h00;
   logic [DATA_W-1:0]    data_wdata = 8'h00, data_rdata, sfr_rdata, status_reg, ind_ptr;
   logic [DATA_W-1:0]    sfr_wdata;
   logic [PROG_AW-1:0]   prog_word_addr;
   logic                 data_rvalid, sfr_sel, sfr_we, bank_select_bit;
   logic [EADDR_W-1:0]   sfr_addr;
   logic [DATA_W-1:0]    gpr_m [64];
   logic [DATA_W-1:0]    stat_m = 8'h18, ptr_m = 8'h00;
   logic [DATA_W-1:0]    exp_q [$];
   int                   errors = 0, comparisons = 0, seed = 32'h8AEA16B0;

   pdm_memory_map dut (.core_clk(core_clk), .reset(reset), .pc_advance(pc_advance),
      .pc_load(pc_load), .pc_load_value(pc_load_value), .int_take(int_take), .pc(pc),
      .prog_word_addr(prog_word_addr), .data_req(data_req), .data_we(data_we),
      .data_addr(data_addr), .data_wdata(data_wdata), .data_rvalid(data_rvalid),
      .data_rdata(data_rdata), .sfr_sel(sfr_sel), .sfr_we(sfr_we), .sfr_addr(sfr_addr),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .status_reg(status_reg),
      .indirect_pointer_register(ind_ptr), .bank_select_bit(bank_select_bit));
   pdm_sfr_model u_sfr (.core_clk(core_clk), .sfr_sel(sfr_sel), .sfr_addr(sfr_addr),
      .sfr_rdata(sfr_rdata));

   initial forever #5 core_clk = ~core_clk;

   // ----------------------------------------
   // checking and reference model
   // ----------------------------------------
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic results();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : results

   // read value before the access, then apply any write
   function automatic logic [DATA_W-1:0] model(input logic [DADDR_W-1:0] a, input logic we,
                                               input logic [DATA_W-1:0] wd);
      logic [EADDR_W-1:0] e;
      logic [DADDR_W-1:0] o;
      e = (a == 7'h00) ? ptr_m : {stat_m[5], a};
      o = e[6:0];
      model = 8'h00;
      if (o == 7'h03) model = stat_m;
      else if (o == 7'h04) model = ptr_m;
      else if (o < 7'h20) model = e ^ 8'h5A;
      else if (o <= 7'h5F) model = gpr_m[o - 7'h20];
      if (we && o == 7'h03) stat_m = wd;
      else if (we && o == 7'h04) ptr_m = wd;
      else if (we && o >= 7'h20 && o <= 7'h5F) gpr_m[o - 7'h20] = wd;
   endfunction : model

   task automatic access(input logic we, input logic [DADDR_W-1:0] a,
                         input logic [DATA_W-1:0] wd);
      logic [DATA_W-1:0] rd;
      @(negedge core_clk);
      data_req = 1'h1;
      data_we = we;
      data_addr = a;
      data_wdata = wd;
      rd = model(a, we, wd);
      if (!we) exp_q.push_back(rd);
      @(posedge core_clk);
   endtask : access

   task automatic pcs(input logic adv, input logic ld, input logic it,
                      input logic [PC_W-1:0] v, input logic [PC_W-1:0] e);
      @(negedge core_clk);
      pc_advance = adv;
      pc_load = ld;
      int_take = it;
      pc_load_value = v;
      @(posedge core_clk);
      #1;
      check(pc, e);
      check(prog_word_addr, e[9:0]);
   endtask : pcs

   always @(posedge core_clk) begin
      #1;
      if (data_rvalid === 1'h1)
         check(data_rdata, exp_q.size() ? exp_q.pop_front() : 8'hXX);
   end

   // ----------------------------------------
   // stimulus
   // ----------------------------------------
   initial begin
      repeat (12) @(posedge core_clk);
      @(negedge core_clk);
      reset = 1'h0;
      check(pc, 13'h0000);
      check(status_reg, STATUS_RESET);
      check(ind_ptr, 8'h00);
      check(data_rvalid, 1'h0);
      for (int i = 1; i < 5; i++) pcs(1'h1, 1'h0, 1'h0, 13'h0000, PC_W'(i));
      pcs(1'h0, 1'h1, 1'h0, 13'h1FFF, 13'h1FFF);
      pcs(1'h1, 1'h0, 1'h0, 13'h0000, 13'h0000);
      pcs(1'h1, 1'h1, 1'h0, 13'h1ABC, 13'h1ABC);
      pcs(1'h1, 1'h1, 1'h1, 13'h0123, 13'h0004);
      pcs(1'h0, 1'h0, 1'h0, 13'h0ABC, 13'h0004);
      for (int i = 0; i < 64; i++) access(1'h1, 7'h20 + 7'(i), 8'($random(seed)));
      access(1'h1, 7'h03, 8'h20);
      for (int i = 0; i < 64; i++) access(1'h0, 7'h5F - 7'(i), 8'h00);
      check(status_reg, 8'h20);
      check(bank_select_bit, 1'h1);
      access(1'h1, 7'h60, 8'hA5);
      access(1'h0, 7'h60, 8'h00);
      access(1'h0, 7'h7F, 8'h00);
      access(1'h0, 7'h10, 8'h00);
      #1;
      check(sfr_sel, 1'h1);
      check(sfr_addr, 8'h90);
      access(1'h1, 7'h11, 8'h3C);
      #1;
      check(sfr_we, 1'h1);
      check(sfr_wdata, 8'h3C);
      access(1'h1, 7'h04, 8'hA5);
      access(1'h0, 7'h04, 8'h00);
      check(ind_ptr, 8'hA5);
      access(1'h0, 7'h00, 8'h00);
      access(1'h1, 7'h00, 8'h77);
      access(1'h0, 7'h25, 8'h00);
      access(1'h0, 7'h03, 8'h00);
      access(1'h1, 7'h03, 8'h00);
      access(1'h0, 7'h1F, 8'h00);
      #1;
      check(sfr_addr, 8'h1F);
      @(negedge core_clk);
      data_req = 1'h0;
      reset = 1'h1;
      @(negedge core_clk);
      reset = 1'h0;
      stat_m = STATUS_RESET;
      ptr_m = PTR_RESET;
      check(pc, RESET_VECTOR);
      check(ind_ptr, PTR_RESET);
      access(1'h0, 7'h03, 8'h00);
      access(1'h0, 7'h25, 8'h00);
      @(negedge core_clk);
      data_req = 1'h0;
      repeat (3) @(posedge core_clk);
      check(16'(exp_q.size()), 16'h0000);
      results();
   end

   initial begin
      #100000;
      errors++;
      results();
   end
endmodule : pdm_memory_map_bench
